//--- design/sia_i2c_regs.sv
// Two-wire serial slave front end with the identification, reset and interrupt config registers
// Summary of operation
// - Answer only slave address 0x37; ignore every other address.
// - Registers are reached only through the two-wire serial slave port.
// - All registers take defaults at power-up and on software reset.
// - Register 0x00 is read-only and returns part and revision identification.
// - Reset bit set, then STOP, returns device to default standby state.
// - Reset register bit 0 requests reset, default 0; bits 7:1 ignored.
// - Register 0x02 holds the interrupt pin configuration, read-write.
// - Register address advances by one after each data byte, acknowledged or not.
`timescale 1ns/1ps
`default_nettype none
module sia_i2c_regs import sia_pkg::*; #(
   parameter logic [7:0] PART_IDENTIFICATION = SIA_PART_IDENTIFICATION_VAL
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   output logic [7:0] intPinConfig,
   output logic softResetPulse
);
   sia_state_t state;
   sia_line_t prevLine;
   logic [3:0] bitCnt;
   logic [7:0] shift;
   logic [7:0] ptr;
   logic nack;
   logic resetBit;

   wire sia_line_t curLine = '{scl: sclIn, sda: sdaIn};
   wire logic sclRise = curLine.scl & ~prevLine.scl;
   wire logic sclFall = ~curLine.scl & prevLine.scl;
   wire logic startDet = curLine.scl & prevLine.scl & prevLine.sda & ~curLine.sda;
   wire logic stopDet = curLine.scl & prevLine.scl & ~prevLine.sda & curLine.sda;
   wire logic byteFull = (bitCnt == SIA_BITS_PER_BYTE);
   wire logic byteEnd = sclFall & byteFull;
   wire logic recvState = (state == ST_ADDR) || (state == ST_REG) || (state == ST_WDATA);
   wire logic addrMatch = (shift[7:1] == SIA_SLAVE_ADDR);
   wire logic wrHit = (state == ST_WDATA) & byteEnd;
   wire logic wrReset = wrHit & (ptr == SIA_REG_SOFT_RESET);
   wire logic wrIntCfg = wrHit & (ptr == SIA_REG_INT_CFG);
   // reset takes effect on the STOP
   wire logic swReset = stopDet & resetBit;
   wire logic regClr = ~nrst | swReset;
   wire logic [7:0] readData =
      (ptr == SIA_REG_PART_IDENTIFICATION) ? PART_IDENTIFICATION :
      (ptr == SIA_REG_SOFT_RESET) ? {7'h00, resetBit} :
      (ptr == SIA_REG_INT_CFG) ? intPinConfig : SIA_UNMAPPED_READ;

   sia_reg #(.W(1), .RST(SIA_SOFT_RESET_RST)) uResetReg (
      .core_clk(core_clk),
      .clr(regClr),
      .we(wrReset),
      .d(shift[SIA_RESET_BIT]),
      .q(resetBit)
   );

   sia_reg #(.W(8), .RST(SIA_INT_CFG_RST)) uIntCfgReg (
      .core_clk(core_clk),
      .clr(regClr),
      .we(wrIntCfg),
      .d(shift),
      .q(intPinConfig)
   );

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         prevLine <= '1;
         sdaOut <= 1'b0;
         softResetPulse <= 1'b0;
      end else begin
         prevLine <= curLine;
         sdaOut <= 1'b0;
         softResetPulse <= swReset;
      end
   end

   // all register traffic comes through this slave
   always_ff @(posedge core_clk) begin
      if (regClr) begin
         state <= ST_IDLE;
         bitCnt <= SIA_BIT_CNT_RST;
         shift <= 8'h00;
         ptr <= SIA_PTR_RST;
         sdaOe <= 1'b0;
         nack <= 1'b0;
      end else if (startDet) begin
         // Repeated start also lands here, so a read can follow the pointer write
         state <= ST_ADDR;
         bitCnt <= SIA_BIT_CNT_RST;
         sdaOe <= 1'b0;
      end else if (stopDet) begin
         state <= ST_IDLE;
         sdaOe <= 1'b0;
      end else begin
         unique case (state)
            ST_IDLE: begin
            end
            ST_ADDR, ST_REG, ST_WDATA: begin
               if (sclRise && !byteFull) begin
                  shift <= {shift[6:0], curLine.sda};
                  bitCnt <= bitCnt + 4'h1;
               end else if (byteEnd) begin
                  bitCnt <= SIA_BIT_CNT_RST;
                  if (state == ST_ADDR) begin
                     // foreign address leaves the bus alone
                     sdaOe <= addrMatch;
                     state <= addrMatch ? ST_ADDR_ACK : ST_IDLE;
                  end else begin
                     sdaOe <= 1'b1;
                     state <= ST_WACK;
                     ptr <= (state == ST_REG) ? shift : ptr + 8'h01;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (sclFall) begin
                  if (shift[0]) begin
                     shift <= readData;
                     sdaOe <= ~readData[7];
                     state <= ST_RDATA;
                  end else begin
                     // write direction selects the pointer phase
                     sdaOe <= 1'b0;
                     state <= ST_REG;
                  end
               end
            end
            ST_WACK: begin
               if (sclFall) begin
                  sdaOe <= 1'b0;
                  state <= ST_WDATA;
               end
            end
            ST_RDATA: begin
               if (sclRise) begin
                  bitCnt <= bitCnt + 4'h1;
               end else if (sclFall) begin
                  if (byteFull) begin
                     sdaOe <= 1'b0;
                     bitCnt <= SIA_BIT_CNT_RST;
                     ptr <= ptr + 8'h01;
                     state <= ST_MACK;
                  end else begin
                     shift <= {shift[6:0], 1'b0};
                     sdaOe <= ~shift[6];
                  end
               end
            end
            ST_MACK: begin
               if (sclRise) begin
                  nack <= curLine.sda;
               end else if (sclFall) begin
                  if (nack) begin
                     state <= ST_IDLE;
                  end else begin
                     shift <= readData;
                     sdaOe <= ~readData[7];
                     state <= ST_RDATA;
                  end
               end
            end
         endcase
      end
   end

   default clocking cbMain @(posedge core_clk);
   endclocking
   default disable iff (!nrst);

   sequence s_reset_armed;
      resetBit ##0 stopDet;
   endsequence

   sequence s_defaults;
      softResetPulse && (intPinConfig == SIA_INT_CFG_RST) && !resetBit;
   endsequence

   sequence s_addr_done;
      (state == ST_ADDR) && byteEnd && !startDet && !stopDet;
   endsequence

   property p_addr_ignore;
      s_addr_done ##0 !addrMatch |=> (state == ST_IDLE) && !sdaOe;
   endproperty
   a_addr_ignore: assert property (p_addr_ignore) else $error("foreign address not ignored");

   property p_addr_ack;
      s_addr_done ##0 addrMatch |=> (state == ST_ADDR_ACK) && sdaOe;
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged");

   property p_soft_reset;
      s_reset_armed |=> s_defaults ##0 (state == ST_IDLE);
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset missed on stop");

   property p_id_read;
      (state == ST_ADDR_ACK) && sclFall && shift[0] && (ptr == SIA_REG_PART_IDENTIFICATION)
         && !startDet && !stopDet |=> (shift == PART_IDENTIFICATION) && (state == ST_RDATA);
   endproperty
   a_id_read: assert property (p_id_read) else $error("identification not returned");

   property p_id_no_write;
      (ptr == SIA_REG_PART_IDENTIFICATION) && wrHit |=> $stable(intPinConfig) && $stable(resetBit) && sdaOe;
   endproperty
   a_id_no_write: assert property (p_id_no_write) else $error("write to id had effect");

   property p_ptr_step;
      (state == ST_WDATA) && byteEnd && !startDet && !stopDet |=> ptr == $past(ptr) + 8'h01;
   endproperty
   a_ptr_step: assert property (p_ptr_step) else $error("address did not advance");

   property p_cfg_source;
      !$stable(intPinConfig) |-> $past(wrIntCfg) || $past(swReset);
   endproperty
   a_cfg_source: assert property (p_cfg_source) else $error("config changed without a write");

   property p_cfg_write;
      wrIntCfg && !swReset |=> intPinConfig == $past(shift);
   endproperty
   a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

   property p_reset_bit0;
      wrReset && !swReset |=> resetBit == $past(shift[SIA_RESET_BIT])
         ##1 (!softResetPulse || $past(resetBit));
   endproperty
   a_reset_bit0: assert property (p_reset_bit0) else $error("reset bit not stored from bit 0");
endmodule : sia_i2c_regs
`default_nettype wire

//--- design/sia_pkg.sv
// Constants and types shared by the serial register access block
package sia_pkg;
   localparam logic [6:0] SIA_SLAVE_ADDR = 7'h37;
   localparam logic [7:0] SIA_REG_PART_IDENTIFICATION = 8'h00;
   localparam logic [7:0] SIA_REG_SOFT_RESET = 8'h01;
   localparam logic [7:0] SIA_REG_INT_CFG = 8'h02;
   localparam int SIA_RESET_BIT = 0;
   // Arbitrary identification value, not a real part code
   localparam logic [7:0] SIA_PART_IDENTIFICATION_VAL = 8'h5a;
   localparam logic SIA_SOFT_RESET_RST = 1'b0;
   localparam logic [7:0] SIA_INT_CFG_RST = 8'h00;
   localparam logic [7:0] SIA_UNMAPPED_READ = 8'h00;
   localparam logic [3:0] SIA_BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] SIA_BIT_CNT_RST = 4'h0;
   localparam logic [7:0] SIA_PTR_RST = 8'h00;

   typedef enum {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_WDATA, ST_WACK, ST_RDATA, ST_MACK
   } sia_state_t;

   typedef struct packed {
      logic scl;
      logic sda;
   } sia_line_t;
endpackage : sia_pkg

//--- design/sia_reg.sv
// One writable register with clear-to-default
`timescale 1ns/1ps
`default_nettype none
module sia_reg #(
   parameter int W = 8,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic core_clk,
   input wire logic clr,
   input wire logic we,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   always_ff @(posedge core_clk) begin
      if (clr) begin
         q <= RST;
      end else if (we) begin
         q <= d;
      end
   end
endmodule : sia_reg
`default_nettype wire

//--- verif/sia_bm.sv
// Behavioural two-wire bus master for the register access block
`timescale 1ns/1ps
`default_nettype none
module sia_bm (
   input wire logic core_clk,
   input wire logic sda,
   output logic scl,
   output logic sdaLow
);
   initial begin
      scl = 1'b1;
      sdaLow = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(negedge core_clk);
   endtask : hold
   // Doubles as repeated start when the clock is low
   task automatic start();
      sdaLow = 1'b0;
      hold(4);
      scl = 1'b1;
      hold(4);
      sdaLow = 1'b1;
      hold(4);
      scl = 1'b0;
      hold(2);
   endtask : start
   task automatic stop();
      sdaLow = 1'b1;
      hold(4);
      scl = 1'b1;
      hold(4);
      sdaLow = 1'b0;
      hold(4);
   endtask : stop
   // Data moves only while the clock is low
   task automatic xfer(input logic b, output logic r);
      sdaLow = ~b;
      hold(4);
      scl = 1'b1;
      hold(4);
      r = sda;
      scl = 1'b0;
      hold(2);
   endtask : xfer
   task automatic put(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) xfer(d[i], r);
      xfer(1'b1, r);
      ack = ~r;
   endtask : put
   task automatic get(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         xfer(1'b1, r);
         d[i] = r;
      end
      xfer(nack, r);
   endtask : get
endmodule : sia_bm
`default_nettype wire

//--- verif/tb_sia_i2c_regs.sv
// Self-checking bench for the serial register access block
`timescale 1ns/1ps
`default_nettype none
module tb_sia_i2c_regs import sia_pkg::*;;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic scl, sdaLow, sdaOut, sdaOe, softResetPulse, sda, a;
   logic [7:0] intPinConfig;
   logic [23:0] q;
   int miscompares = 0;
   int checked = 0;
   int pulses = 0;
   int cycles = 0;
   always #10 core_clk = ~core_clk;
   // Open-drain wire with pull-up
   assign sda = ~(sdaLow | sdaOe);
   sia_bm sia_bm_inst (.core_clk(core_clk), .sda(sda), .scl(scl), .sdaLow(sdaLow));
   sia_i2c_regs sia_i2c_regs_inst (.core_clk(core_clk), .nrst(nrst), .sclIn(scl),
      .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .intPinConfig(intPinConfig),
      .softResetPulse(softResetPulse));
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (softResetPulse === 1'b1) pulses <= pulses + 1;
   end
   always @(negedge core_clk) begin
      if (cycles == 20000) begin
         miscompares++;
         wrap_up();
      end
   end
   task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string s);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t %s: got %h want %h", $time, s, got, exp);
      end
   endtask : chk
   task automatic chkBit(input logic got, input logic exp, input string s);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t %s: got %b want %b", $time, s, got, exp);
      end
   endtask : chkBit
   task automatic wr(input logic [6:0] dev, input logic [7:0] ra, input logic [23:0] d,
         input int n, output logic ok);
      logic k;
      sia_bm_inst.start();
      sia_bm_inst.put({dev, 1'b0}, ok);
      sia_bm_inst.put(ra, k);
      ok &= k;
      for (int i = n - 1; i >= 0; i--) begin
         sia_bm_inst.put(d[8*i +: 8], k);
         ok &= k;
      end
      sia_bm_inst.stop();
   endtask : wr
   // pointer set by a write-direction frame first
   task automatic rd(input logic [7:0] ra, input int n, output logic [23:0] d);
      logic k;
      d = '0;
      wr(SIA_SLAVE_ADDR, ra, 24'h0, 0, k);
      sia_bm_inst.start();
      sia_bm_inst.put({SIA_SLAVE_ADDR, 1'b1}, k);
      for (int i = n - 1; i >= 0; i--) sia_bm_inst.get(i == 0, d[8*i +: 8]);
      sia_bm_inst.stop();
   endtask : rd
   task automatic wrap_up();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : wrap_up
   initial begin
      repeat (2) @(negedge core_clk);
      nrst = 1'b1;
      @(negedge core_clk);
      chk({16'h0, intPinConfig}, {16'h0, SIA_INT_CFG_RST}, "config default");
      rd(SIA_REG_PART_IDENTIFICATION, 3, q);
      chk(q, {SIA_PART_IDENTIFICATION_VAL, 7'h0, SIA_SOFT_RESET_RST, SIA_INT_CFG_RST}, "defaults");
      $display("defaults test done");
      wr(SIA_SLAVE_ADDR, SIA_REG_INT_CFG, 24'ha5, 1, a);
      chkBit(a, 1'b1, "write ack");
      chk({16'h0, intPinConfig}, 24'ha5, "config pin");
      chkBit(sdaOut, 1'b0, "open drain level");
      wr(7'h38, SIA_REG_INT_CFG, 24'h5c, 1, a);
      chkBit(a, 1'b0, "foreign ack");
      chk({16'h0, intPinConfig}, 24'ha5, "foreign ignored");
      // Second byte comes from the first unmapped offset
      rd(SIA_REG_INT_CFG, 2, q);
      chk(q, {8'h00, 8'ha5, SIA_UNMAPPED_READ}, "config readback");
      $display("address test done");
      // Bit 0 clear, so no reset despite upper bits set
      wr(SIA_SLAVE_ADDR, SIA_REG_PART_IDENTIFICATION, 24'h11fe3c, 3, a);
      chkBit(a, 1'b1, "block ack");
      rd(SIA_REG_PART_IDENTIFICATION, 3, q);
      chk(q, {SIA_PART_IDENTIFICATION_VAL, 16'h003c}, "block write");
      chk(24'(pulses), 24'h0, "no reset");
      $display("block test done");
      wr(SIA_SLAVE_ADDR, SIA_REG_SOFT_RESET, 24'h01, 1, a);
      chkBit(a, 1'b1, "reset write ack");
      chk(24'(pulses), 24'h1, "reset pulse");
      chk({16'h0, intPinConfig}, 24'h0, "config cleared");
      rd(SIA_REG_PART_IDENTIFICATION, 3, q);
      chk(q, {SIA_PART_IDENTIFICATION_VAL, 16'h0}, "after reset");
      $display("reset test done");
      wrap_up();
   end
endmodule : tb_sia_i2c_regs
`default_nettype wire
